// ===== verilog/ulmc_pkg.sv
`default_nettype none
package ulmc_pkg;
  // register byte addresses within the port window
  localparam logic [31:0] ADDR_LINE_CONTROL  = 32'h5000110c;
  localparam logic [31:0] ADDR_MODEM_CONTROL = 32'h50001110;
  // shared offsets reached while divisor access is selected
  localparam logic [31:0] ADDR_DIV_LOW       = 32'h50001100;
  localparam logic [31:0] ADDR_DIV_HIGH      = 32'h50001104;
  // fifo enable / line status readback, own choice
  localparam logic [31:0] ADDR_FIFO_CTRL     = 32'h50001108;
  localparam logic [31:0] ADDR_LINE_STATUS   = 32'h50001114;
  localparam logic [31:0] ADDR_TX_DATA       = 32'h50001100;

  localparam int LCR_DIV_ACCESS_POS = 7;
  localparam int LCR_BREAK_POS      = 6;
  localparam int LCR_EVEN_PAR_POS   = 4;
  localparam int LCR_PAR_ON_POS     = 3;
  localparam int LCR_STOP_POS       = 2;
  localparam int MCR_IR_POS         = 6;
  localparam int MCR_AUTOHS_POS     = 5;
  localparam int MCR_LOOP_POS       = 4;
  localparam int MCR_RTS_POS        = 1;
  localparam int FCR_FIFO_ON_POS    = 0;

  localparam logic [7:0]  LCR_WMASK = 8'hdf;
  localparam logic [6:0]  MCR_WMASK = 7'h7e;
  localparam logic [7:0]  LCR_RESET = 8'h00;
  localparam logic [6:0]  MCR_RESET = 7'h00;
  localparam logic [15:0] DIV_RESET = 16'h0000;

  // ir pulse is 3/16 of a bit time
  localparam int IR_PULSE_SIXTEENTHS = 3;
endpackage : ulmc_pkg
`default_nettype wire

// ===== verilog/ulmc_serializer.sv
`timescale 1ns/10ps
`default_nettype none
module ulmc_serializer
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // configuration
  input  wire logic [1:0]  i_char_length_field,
  input  wire logic        i_parity_on,
  input  wire logic        i_even_parity_pick,
  input  wire logic        i_two_stop,
  input  wire logic        i_tick16,
  // character handoff
  input  wire logic        i_start,
  input  wire logic [7:0]  i_data,
  output logic             o_busy,
  output logic             o_line
);
  typedef enum logic [1:0]
  {
    ULMC_IDLE = 2'b00,
    ULMC_SHIFT = 2'b01
  } ulmc_ser_t;

  ulmc_ser_t  state_reg;
  logic [11:0] frame_reg;
  logic [5:0]  half_reg;
  logic [3:0]  sub_reg;
  logic [5:0]  half_total;
  logic [3:0]  nbits;
  logic        par_bit;
  logic [11:0] frame_next;

  // frame built as start, data lsb first, parity, stop
  always_comb
  begin
    nbits = 4'd5 + {2'b00, i_char_length_field};
    par_bit = ^(i_data & (8'hff >> (4'd8 - nbits)));
    par_bit = i_even_parity_pick ? par_bit : ~par_bit;
    frame_next = {12'hfff};
    frame_next[0] = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      if (k < int'(nbits))
        frame_next[k + 1] = i_data[k];
    end
    if (i_parity_on)
      frame_next[nbits + 4'd1] = par_bit;
    // counts in half bits: 1.5 stop only for 5 bit chars
    half_total = {1'b0, nbits, 1'b0} + 6'd4 +
                 (i_parity_on ? 6'd2 : 6'd0) +
                 (i_two_stop ? ((nbits == 4'd5) ? 6'd1 : 6'd2) : 6'd0);
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= ULMC_IDLE;
      frame_reg <= 12'hfff;
      half_reg  <= 6'h00;
      sub_reg   <= 4'h0;
    end
    else if (state_reg == ULMC_IDLE)
    begin
      if (i_start)
      begin
        state_reg <= ULMC_SHIFT;
        frame_reg <= frame_next;
        half_reg  <= half_total;
        sub_reg   <= 4'h0;
      end
    end
    else if (i_tick16)
    begin
      sub_reg <= sub_reg + 4'h1;
      if (sub_reg[2:0] == 3'h7)
      begin
        half_reg <= half_reg - 6'h01;
        if (sub_reg == 4'hf)
          frame_reg <= {1'b1, frame_reg[11:1]};
        if (half_reg == 6'h01)
          state_reg <= ULMC_IDLE;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_busy <= 1'b0;
      o_line <= 1'b1;
    end
    else
    begin
      o_busy <= (state_reg != ULMC_IDLE);
      o_line <= (state_reg == ULMC_IDLE) ? 1'b1 : frame_reg[0];
    end
  end
endmodule : ulmc_serializer
`default_nettype wire

// ===== verilog/ulmc_top.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - divisor access bit set maps shared offsets to baud divisor low/high
// - break force drives serial output to spacing, logic zero
// - outside loopback transmit line stays low while break bit is set
// - break with infrared mode keeps pulsing infrared output
// - break in loopback loops to receiver, infrared output low
// - even parity pick gives even count of ones, else odd
// - parity on adds parity on transmit and checks it on receive
// - stop bit gives one, or 1.5 for 5-bit chars, else two
// - receiver validates only the first stop bit
// - char length field selects five to eight data bits
// - infrared mode bit switches port to SIR signalling
// - auto handshake needs fifos enabled and auto handshake bit
// - loopback without infrared holds line high, loops output to input
module ulmc_top
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // register port
  input  wire logic [31:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // serial line
  input  wire logic        i_sin,
  input  wire logic        i_sir_in,
  input  wire logic        i_cts_n,
  output logic             o_sout,
  output logic             o_sir_out_n,
  output logic             o_rts_n,
  // baud setup and status
  output logic      [15:0] o_baud_divisor,
  output logic             o_rx_valid,
  output logic      [7:0]  o_rx_data,
  output logic             o_parity_err,
  output logic             o_frame_err,
  output logic             o_break_seen
);
  logic [7:0]  line_control_reg;
  logic [6:0]  modem_control_reg;
  logic [15:0] div_reg;
  logic        fifo_on_reg;
  logic [15:0] baud_cnt_reg;
  logic        tick16_reg;
  logic [2:0]  sin_sync_reg;
  logic [1:0]  cts_sync_reg;
  logic [1:0]  sir_sync_reg;
  logic        tx_start_reg;
  logic [7:0]  tx_data_reg;
  logic        tx_busy;
  logic        tx_line;
  logic [3:0]  ir_sub_reg;
  logic [7:0]  rx_sh_reg;
  logic [3:0]  rx_sub_reg;
  logic [3:0]  rx_idx_reg;
  logic        rx_act_reg;
  logic        rx_par_reg;
  logic        divisor_access_select;
  logic        break_force;
  logic        loopback_select;
  logic        infrared_mode_on;
  logic        auto_handshake_on;
  logic        rx_in;
  logic        ser_out;
  logic        ir_pulse;
  logic        hs_active;
  logic [3:0]  nbits;

  assign divisor_access_select = line_control_reg[ulmc_pkg::LCR_DIV_ACCESS_POS];
  assign break_force       = line_control_reg[ulmc_pkg::LCR_BREAK_POS];
  assign loopback_select   = modem_control_reg[ulmc_pkg::MCR_LOOP_POS];
  assign infrared_mode_on  = modem_control_reg[ulmc_pkg::MCR_IR_POS];
  assign auto_handshake_on = modem_control_reg[ulmc_pkg::MCR_AUTOHS_POS];
  assign nbits = 4'd5 + {2'b00, line_control_reg[1:0]};

  // handshake only with fifos on and auto bit set
  assign hs_active = fifo_on_reg && auto_handshake_on;
  // break forces the internal serial output to spacing
  assign ser_out = break_force ? 1'b0 : tx_line;
  // ir pulse marks a zero bit while the free-running sixteenth count is below three
  assign ir_pulse = ~ser_out &&
    (ir_sub_reg < 4'(ulmc_pkg::IR_PULSE_SIXTEENTHS));
  // loopback feeds output (incl. break) to own receiver
  assign rx_in = loopback_select ? ser_out :
                 (infrared_mode_on ? ~sir_sync_reg[1] : sin_sync_reg[2]);

  // line control register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      line_control_reg <= ulmc_pkg::LCR_RESET;
    else if (i_wr && i_addr == ulmc_pkg::ADDR_LINE_CONTROL)
      line_control_reg <= i_wdata[7:0] & ulmc_pkg::LCR_WMASK;
  end

  // modem control register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      modem_control_reg <= ulmc_pkg::MCR_RESET;
    else if (i_wr && i_addr == ulmc_pkg::ADDR_MODEM_CONTROL)
      modem_control_reg <= i_wdata[6:0] & ulmc_pkg::MCR_WMASK;
  end

  // divisor halves behind the access bit
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      div_reg <= ulmc_pkg::DIV_RESET;
    else if (i_wr && divisor_access_select)
    begin
      if (i_addr == ulmc_pkg::ADDR_DIV_LOW)
        div_reg[7:0] <= i_wdata[7:0];
      else if (i_addr == ulmc_pkg::ADDR_DIV_HIGH)
        div_reg[15:8] <= i_wdata[7:0];
    end
  end

  // fifo enable and transmit data
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fifo_on_reg  <= 1'b0;
      tx_start_reg <= 1'b0;
      tx_data_reg  <= 8'h00;
    end
    else
    begin
      tx_start_reg <= 1'b0;
      if (i_wr && i_addr == ulmc_pkg::ADDR_FIFO_CTRL)
        fifo_on_reg <= i_wdata[ulmc_pkg::FCR_FIFO_ON_POS];
      else if (i_wr && !divisor_access_select &&
               i_addr == ulmc_pkg::ADDR_TX_DATA && !tx_busy &&
               !(hs_active && cts_sync_reg[1]))
      begin
        tx_start_reg <= 1'b1;
        tx_data_reg  <= i_wdata[7:0];
      end
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= 16'h0000;
    else if (!i_rd)
      o_rdata <= 16'h0000;
    else if (i_addr == ulmc_pkg::ADDR_LINE_CONTROL)
      o_rdata <= {8'h00, line_control_reg};
    else if (i_addr == ulmc_pkg::ADDR_MODEM_CONTROL)
      o_rdata <= {9'h000, modem_control_reg};
    else if (divisor_access_select && i_addr == ulmc_pkg::ADDR_DIV_LOW)
      o_rdata <= {8'h00, div_reg[7:0]};
    else if (divisor_access_select && i_addr == ulmc_pkg::ADDR_DIV_HIGH)
      o_rdata <= {8'h00, div_reg[15:8]};
    else if (i_addr == ulmc_pkg::ADDR_LINE_STATUS)
      o_rdata <= {11'h000, tx_busy, o_break_seen, o_frame_err,
                  o_parity_err, o_rx_valid};
    else
      o_rdata <= 16'h0000;
  end

  // 16x baud tick; divisor zero stops it
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      baud_cnt_reg <= 16'h0000;
      tick16_reg   <= 1'b0;
    end
    else if (div_reg == 16'h0000)
    begin
      baud_cnt_reg <= 16'h0000;
      tick16_reg   <= 1'b0;
    end
    else if (baud_cnt_reg >= div_reg - 16'h0001)
    begin
      baud_cnt_reg <= 16'h0000;
      tick16_reg   <= 1'b1;
    end
    else
    begin
      baud_cnt_reg <= baud_cnt_reg + 16'h0001;
      tick16_reg   <= 1'b0;
    end
  end

  // pin synchronisers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sin_sync_reg <= 3'h7;
      cts_sync_reg <= 2'h3;
      sir_sync_reg <= 2'h3;
    end
    else
    begin
      sin_sync_reg <= {sin_sync_reg[1:0], i_sin};
      cts_sync_reg <= {cts_sync_reg[0], i_cts_n};
      sir_sync_reg <= {sir_sync_reg[0], i_sir_in};
    end
  end

  // ir sixteenth counter runs free, so break keeps pulsing
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ir_sub_reg <= 4'h0;
    else if (tick16_reg)
      ir_sub_reg <= ir_sub_reg + 4'h1;
  end

  ulmc_serializer u_ser
  (
    .i_clk               (i_clk),
    .i_rst_n             (i_rst_n),
    .i_char_length_field (line_control_reg[1:0]),
    .i_parity_on         (line_control_reg[ulmc_pkg::LCR_PAR_ON_POS]),
    .i_even_parity_pick  (line_control_reg[ulmc_pkg::LCR_EVEN_PAR_POS]),
    .i_two_stop          (line_control_reg[ulmc_pkg::LCR_STOP_POS]),
    .i_tick16            (tick16_reg),
    .i_start             (tx_start_reg),
    .i_data              (tx_data_reg),
    .o_busy              (tx_busy),
    .o_line              (tx_line)
  );

  // line outputs by mode
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_sout      <= 1'b1;
      o_sir_out_n <= 1'b1;
      o_rts_n     <= 1'b1;
    end
    else
    begin
      // break holds sout low in sir mode too, outside loopback
      o_sout <= loopback_select ? 1'b1 :
                (infrared_mode_on ? !break_force : ser_out);
      if (loopback_select)
        o_sir_out_n <= 1'b0;
      else
        o_sir_out_n <= infrared_mode_on ? ~ir_pulse : 1'b1;
      if (loopback_select)
        o_rts_n <= 1'b1;
      else
        o_rts_n <= ~(modem_control_reg[ulmc_pkg::MCR_RTS_POS] &&
                     !(hs_active && o_rx_valid));
    end
  end

  assign o_baud_divisor = div_reg;

  // receiver: mid-bit sampling, first stop only
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_act_reg   <= 1'b0;
      rx_sub_reg   <= 4'h0;
      rx_idx_reg   <= 4'h0;
      rx_sh_reg    <= 8'h00;
      rx_par_reg   <= 1'b0;
      o_rx_valid   <= 1'b0;
      o_rx_data    <= 8'h00;
      o_parity_err <= 1'b0;
      o_frame_err  <= 1'b0;
      o_break_seen <= 1'b0;
    end
    else
    begin
      o_rx_valid <= 1'b0;
      if (!rx_act_reg)
      begin
        if (tick16_reg && !rx_in)
        begin
          rx_act_reg <= 1'b1;
          rx_sub_reg <= 4'h1;
          rx_idx_reg <= 4'h0;
          rx_sh_reg  <= 8'h00;
          rx_par_reg <= 1'b0;
        end
      end
      else if (tick16_reg)
      begin
        rx_sub_reg <= rx_sub_reg + 4'h1;
        if (rx_sub_reg == 4'h7)
        begin
          rx_idx_reg <= rx_idx_reg + 4'h1;
          if (rx_idx_reg == 4'h0)
            rx_act_reg <= ~rx_in;
          else if (rx_idx_reg <= nbits)
          begin
            rx_sh_reg[rx_idx_reg[2:0] - 3'h1] <= rx_in;
            rx_par_reg <= rx_par_reg ^ rx_in;
          end
          else if (line_control_reg[ulmc_pkg::LCR_PAR_ON_POS] &&
                   rx_idx_reg == nbits + 4'd1)
            rx_par_reg <= rx_par_reg ^ rx_in;
          else
          begin
            rx_act_reg   <= 1'b0;
            o_rx_valid   <= 1'b1;
            o_rx_data    <= rx_sh_reg;
            o_frame_err  <= ~rx_in;
            o_break_seen <= ~rx_in && (rx_sh_reg == 8'h00);
            // odd total wanted when even pick is clear
            o_parity_err <= line_control_reg[ulmc_pkg::LCR_PAR_ON_POS] &&
              (rx_par_reg ^
               ~line_control_reg[ulmc_pkg::LCR_EVEN_PAR_POS]);
          end
        end
      end
    end
  end
endmodule : ulmc_top
`default_nettype wire

// ===== test/ulmc_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ulmc_checker
(
  // watched ports
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [31:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [15:0] o_rdata,
  input  wire logic        o_sout,
  input  wire logic        o_sir_out_n,
  input  wire logic        o_rts_n,
  input  wire logic [15:0] o_baud_divisor
);
  logic [7:0] lcr_reg;
  logic [6:0] mcr_reg;
  logic [2:0] age_reg;
  logic       a_lcr;
  logic       a_mcr;
  logic       a_dl;
  logic       cfg_old;
  assign a_lcr = i_addr == ulmc_pkg::ADDR_LINE_CONTROL;
  assign a_mcr = i_addr == ulmc_pkg::ADDR_MODEM_CONTROL;
  assign a_dl  = i_addr == ulmc_pkg::ADDR_DIV_LOW;
  // settled: seven cycles since the last write
  assign cfg_old = age_reg == 3'h7;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lcr_reg <= ulmc_pkg::LCR_RESET;
      mcr_reg <= ulmc_pkg::MCR_RESET;
    end
    else if (i_wr && a_lcr)
      lcr_reg <= i_wdata[7:0] & ulmc_pkg::LCR_WMASK;
    else if (i_wr && a_mcr)
      mcr_reg <= i_wdata[6:0] & ulmc_pkg::MCR_WMASK;
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      age_reg <= 3'h0;
    else if (i_wr)
      age_reg <= 3'h0;
    else if (!cfg_old)
      age_reg <= age_reg + 3'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_DIV_LOAD:
    assert property (i_wr && lcr_reg[7] && a_dl |=>
      o_baud_divisor[7:0] == $past(i_wdata[7:0]))
    else $error("divisor low not loaded");
  AST_DIV_READ:
    assert property (i_rd && lcr_reg[7] && a_dl |=>
      o_rdata == {8'h00, o_baud_divisor[7:0]})
    else $error("divisor low readback wrong");
  AST_LCR_READ:
    assert property (i_rd && a_lcr |=> o_rdata == {8'h00, $past(lcr_reg)})
    else $error("line control readback wrong");
  AST_MCR_READ:
    assert property (i_rd && a_mcr |=> o_rdata == {9'h000, $past(mcr_reg)})
    else $error("modem control readback wrong");
  AST_BREAK_LOW:
    assert property (lcr_reg[6] && !mcr_reg[4] && cfg_old |-> !o_sout)
    else $error("break not holding line low");
  AST_LOOP_LINES:
    assert property (mcr_reg[4] && cfg_old |->
      o_sout && !o_sir_out_n && o_rts_n)
    else $error("loopback pin levels wrong");
  AST_RTS_OFF:
    assert property (!mcr_reg[4] && !mcr_reg[1] && cfg_old |-> o_rts_n)
    else $error("rts asserted while request bit clear");
  AST_IR_IDLE:
    assert property (!mcr_reg[6] && !mcr_reg[4] && cfg_old |-> o_sir_out_n)
    else $error("infrared output active outside sir mode");
endmodule : ulmc_checker
`default_nettype wire

// ===== test/ulmc_partner.sv
`timescale 1ns/10ps
`default_nettype none
module ulmc_partner
#(
  parameter int BIT_CYC = 32
)
(
  input  wire logic       i_clk,
  input  wire logic       i_line,
  input  wire logic       i_listen,
  input  wire logic [1:0] i_len,
  input  wire logic       i_par_on,
  input  wire logic       i_even,
  output logic            o_sin,
  output logic            o_got,
  output logic [9:0]      o_word
);
  logic [7:0] d;
  logic       p;
  initial
  begin
    o_sin = 1'b1;
    o_got = 1'b0;
    o_word = 10'h000;
  end
  function automatic logic par(input logic [7:0] v, input logic [1:0] n,
                               input logic even);
    logic x;
    x = ^(v & (8'hff >> (3 - n)));
    return even ? x : ~x;
  endfunction : par
  task automatic bit_out(input logic b);
    o_sin <= b;
    repeat (BIT_CYC) @(posedge i_clk);
  endtask : bit_out
  // start, data lsb first, parity, two stop bits
  task automatic send(input logic [7:0] v, input logic bp, input logic bs);
    bit_out(1'b0);
    for (int i = 0; i < 5 + i_len; i++)
      bit_out(v[i]);
    if (i_par_on)
      bit_out(par(v, i_len, i_even) ^ bp);
    // a bad stop is cut short so no false start follows it
    o_sin <= ~bs;
    repeat (bs ? BIT_CYC * 3 / 4 : BIT_CYC) @(posedge i_clk);
    bit_out(1'b1);
  endtask : send
  // decode one character, first stop bit only
  always
  begin
    @(negedge i_line iff i_listen);
    repeat (BIT_CYC / 2) @(posedge i_clk);
    d = 8'h00;
    p = 1'b0;
    for (int i = 0; i < 5 + i_len; i++)
    begin
      repeat (BIT_CYC) @(posedge i_clk);
      d[i] = i_line;
    end
    if (i_par_on)
    begin
      repeat (BIT_CYC) @(posedge i_clk);
      p = i_line;
    end
    repeat (BIT_CYC) @(posedge i_clk);
    o_word <= {i_line, p, d};
    o_got <= 1'b1;
    @(posedge i_clk);
    o_got <= 1'b0;
  end
endmodule : ulmc_partner
`default_nettype wire

// ===== test/test_ulmc_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_ulmc_top;
  logic        clk, rst_n, wr, rd, rd_d, sin, sout, sir_n, rts_n, cts_n;
  logic        rxv, perr, ferr, brk, got, listen, pon, even, ign;
  logic [31:0] addr, seed;
  logic [15:0] wdata, rdata, div;
  logic [15:0] rd_q[$], rx_q[$], tx_q[$];
  logic [9:0]  word;
  logic [7:0]  rxd, d;
  logic [1:0]  len;
  int          err_total, total_checks, n;
  ulmc_top uut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sin(sin), .i_sir_in(1'b1),
    .i_cts_n(cts_n), .o_sout(sout), .o_sir_out_n(sir_n), .o_rts_n(rts_n),
    .o_baud_divisor(div), .o_rx_valid(rxv), .o_rx_data(rxd),
    .o_parity_err(perr), .o_frame_err(ferr), .o_break_seen(brk));
  ulmc_partner #(.BIT_CYC(32)) p (.i_clk(clk), .i_line(sout),
    .i_listen(listen), .i_len(len), .i_par_on(pon), .i_even(even),
    .o_sin(sin), .o_got(got), .o_word(word));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic close_out();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic wr_r(input logic [31:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_r
  task automatic rd_r(input logic [31:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask : rd_r
  task automatic drain();
    for (int k = 0; k < 3000 && rx_q.size() + tx_q.size() != 0; k++)
      @(posedge clk);
    chk(16'(rx_q.size() + tx_q.size()), 16'h0000);
  endtask : drain
  always @(posedge clk)
    rd_d <= rd;
  // results are settled by the falling edge
  always @(negedge clk)
  begin
    if (rd_d)
      chk(rdata, rd_q.pop_front());
    if (rxv && !ign)
      chk({5'h00, brk, perr, ferr, rxd}, rx_q.pop_front());
    if (got)
      chk({6'h00, word}, tx_q.pop_front());
  end
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #500000;
    err_total++;
    close_out();
  end
  initial
  begin
    {rst_n, wr, rd, cts_n, listen, pon, even, ign} = 8'h00;
    {addr, wdata, len, seed} = {50'h0, 32'hc795};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_r(ulmc_pkg::ADDR_LINE_CONTROL, 16'h0000);
    rd_r(ulmc_pkg::ADDR_MODEM_CONTROL, 16'h0000);
    rd_r(32'h50001118, 16'h0000);
    wr_r(ulmc_pkg::ADDR_LINE_CONTROL, 16'hffff);
    rd_r(ulmc_pkg::ADDR_LINE_CONTROL, 16'h00df);
    wr_r(ulmc_pkg::ADDR_MODEM_CONTROL, 16'hffff);
    rd_r(ulmc_pkg::ADDR_MODEM_CONTROL, 16'h007e);
    wr_r(ulmc_pkg::ADDR_MODEM_CONTROL, 16'h0000);
    wr_r(ulmc_pkg::ADDR_LINE_CONTROL, 16'h0080);
    wr_r(ulmc_pkg::ADDR_DIV_LOW, 16'h0002);
    wr_r(ulmc_pkg::ADDR_DIV_HIGH, 16'h0000);
    rd_r(ulmc_pkg::ADDR_DIV_LOW, 16'h0002);
    chk(div, 16'h0002);
    wr_r(ulmc_pkg::ADDR_LINE_CONTROL, 16'h0000);
    wr_r(ulmc_pkg::ADDR_DIV_HIGH, 16'h0011);
    chk(div, 16'h0002);
    listen = 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      {even, pon, len} = k[3:0];
      wr_r(ulmc_pkg::ADDR_LINE_CONTROL, {11'h0, even, pon, ^k[1:0], len});
      seed = xs(seed);
      d = seed[7:0] & (8'hff >> (3 - len)) | 8'h01;
      tx_q.push_back({7'h01, pon & p.par(d, len, even), d});
      wr_r(ulmc_pkg::ADDR_TX_DATA, {8'h00, d});
      drain();
      rx_q.push_back({8'h00, d});
      p.send(d, 1'b0, 1'b0);
      drain();
      rx_q.push_back({6'h00, pon, 1'b1, d});
      p.send(d, 1'b1, 1'b1);
      drain();
    end
    {listen, ign} = 2'b01;
    wr_r(ulmc_pkg::ADDR_LINE_CONTROL, 16'h0040);
    repeat (8) @(posedge clk);
    chk({15'h0, sout}, 16'h0000);
    wr_r(ulmc_pkg::ADDR_MODEM_CONTROL, 16'h0040);
    n = 0;
    repeat (100) @(posedge clk) n += int'(!sir_n);
    chk({15'h0, n > 0 && n < 100}, 16'h0001);
    wr_r(ulmc_pkg::ADDR_MODEM_CONTROL, 16'h0010);
    repeat (8) @(posedge clk);
    chk({13'h0, sout, sir_n, rts_n}, 16'h0005);
    repeat (300) @(posedge clk);
    chk({14'h0, brk, ferr}, 16'h0003);
    wr_r(ulmc_pkg::ADDR_LINE_CONTROL, 16'h0000);
    repeat (600) @(posedge clk);
    ign = 1'b0;
    rx_q.push_back(16'h0015);
    wr_r(ulmc_pkg::ADDR_TX_DATA, 16'h0015);
    drain();
    wr_r(ulmc_pkg::ADDR_MODEM_CONTROL, 16'h0002);
    repeat (8) @(posedge clk);
    chk({15'h0, rts_n}, 16'h0000);
    cts_n <= 1'b1;
    wr_r(ulmc_pkg::ADDR_FIFO_CTRL, 16'h0001);
    wr_r(ulmc_pkg::ADDR_MODEM_CONTROL, 16'h0022);
    wr_r(ulmc_pkg::ADDR_TX_DATA, 16'h0015);
    repeat (2) @(posedge clk);
    rd_r(ulmc_pkg::ADDR_LINE_STATUS, 16'h0000);
    cts_n <= 1'b0;
    repeat (4) @(posedge clk);
    wr_r(ulmc_pkg::ADDR_TX_DATA, 16'h0015);
    repeat (2) @(posedge clk);
    rd_r(ulmc_pkg::ADDR_LINE_STATUS, 16'h0010);
    wr_r(ulmc_pkg::ADDR_MODEM_CONTROL, 16'h0000);
    repeat (8) @(posedge clk);
    close_out();
  end
endmodule : test_ulmc_top
bind ulmc_top ulmc_checker chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_sout(o_sout), .o_sir_out_n(o_sir_out_n),
  .o_rts_n(o_rts_n), .o_baud_divisor(o_baud_divisor));
`default_nettype wire
